/* File: inc/pead_pkg.sv */
/*
  constants for the phy event and negotiation diagnostic block.
  assumes a single 50 MHz core clock and 16-bit management registers.
*/
package pead_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0]  EVT_REG_ADDR   = 5'h11;
  localparam logic [4:0]  DIAG_REG_ADDR  = 5'h12;
  localparam logic [15:0] EVT_RESET      = 16'h0000;
  localparam logic [15:0] DIAG_RESET     = 16'h0000;
  localparam int          NUM_EVENTS     = 8;
  localparam int          ENABLE_LSB     = 8;
  // ==========================================================
  // event flag positions
  localparam int BIT_NEG_DONE    = 0;
  localparam int BIT_RFAULT      = 1;
  localparam int BIT_LINK_CHANGE = 2;
  localparam int BIT_PARTNER_ACK = 3;
  localparam int BIT_PDF         = 4;
  localparam int BIT_PAGE_RCVD   = 5;
  localparam int BIT_RX_ERROR    = 6;
  localparam int BIT_JABBER      = 7;
  // ==========================================================
  // diagnostic field positions
  localparam int DIAG_RX_LOCK    = 8;
  localparam int DIAG_RX_SIGNAL  = 9;
  localparam int DIAG_RATE_100   = 10;
  localparam int DIAG_FULL_RESOLVED_FULL_DUPLEX  = 11;
  localparam int DIAG_NEG_FAILED = 12;
endpackage

/* File: core/pead_event_latch.sv */
/*
  eight sticky event flags with clear-on-read; a new event wins over clear.
  assumes event pulses synchronous to core_clk.
*/
module pead_event_latch #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // control
  input  wire logic [WIDTH-1:0] eventIn,
  input  wire logic             clearReq,
  // state
  output logic      [WIDTH-1:0] flags
);
  // refuse an empty flag vector at elaboration
  if (WIDTH < 1) begin : gWidthCheck
    $error("WIDTH must be positive");
  end

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  always_comb begin
    flag_next = (clearReq ? '0 : flag_reg) | eventIn;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags = flag_reg;
endmodule // pead_event_latch

/* File: core/pead_link_edge.sv */
/*
  detects link status falling from ok to fail, one-cycle pulse.
  assumes linkOk synchronous to core_clk.
*/
module pead_link_edge (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // link
  input  wire logic linkOk,
  output logic      linkFail
);
  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = linkOk;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign linkFail = prev_reg & ~linkOk;
endmodule // pead_link_edge

/* File: core/pead_event_diag.sv */
/*
  phy event/interrupt register and auto-negotiation diagnostic register.
  the event register holds eight read-clear event flags in its low byte
  and their interrupt enables in its high byte; the diagnostic register
  reports the outcome of the last negotiation and the receiver status.
  assumes a simple synchronous management register port driven by the
  mii management serial engine: one-cycle read/write strobes with address,
  read data registered and held until the next read.
  assumes event pulses, link status and status levels synchronous to
  core_clk; a level held high on an event input keeps its flag set.
  the drop of linkOk itself, not the fail level, sets the link-change
  flag, so a link that stays down raises it only once.
*/
module pead_event_diag
  import pead_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // management register port
  input  wire logic [4:0]  regAddr,
  input  wire logic        regRead,
  input  wire logic        regWrite,
  input  wire logic [15:0] regWdata,
  output logic      [15:0] regRdata,
  // phy event pulses and link status
  input  wire logic        jabberEvent,
  input  wire logic        rxErrorEvent,
  input  wire logic        pageRcvdEvent,
  input  wire logic        parDetectFaultEvent,
  input  wire logic        partnerAckEvent,
  input  wire logic        linkOk,
  input  wire logic        remoteFaultEvent,
  input  wire logic        negotiationDoneEvent,
  input  wire logic        negotiationFailEvent,
  // phy status levels
  input  wire logic        resolvedFullDuplex,
  input  wire logic        resolved100,
  input  wire logic        rxSignalDetected,
  input  wire logic        rxPllLocked,
  // interrupt toward mac raw interrupt status
  output logic             phyIrq
);
  import pead_pkg::*;

  // ==========================================================
  // helpers
  // all helpers are constant-safe so the elaboration checks can use them
  // a strobe hits a register when its address matches
  function automatic logic regHit(
    input logic       strobe,
    input logic [4:0] addr,
    input logic [4:0] target
  );
    return strobe & (addr == target);
  endfunction

  // one bit set at every event flag position
  function automatic logic [15:0] flagPositions();
    logic [15:0] mask;
    mask                  = '0;
    mask[BIT_NEG_DONE]    = 1'b1;
    mask[BIT_RFAULT]      = 1'b1;
    mask[BIT_LINK_CHANGE] = 1'b1;
    mask[BIT_PARTNER_ACK] = 1'b1;
    mask[BIT_PDF]         = 1'b1;
    mask[BIT_PAGE_RCVD]   = 1'b1;
    mask[BIT_RX_ERROR]    = 1'b1;
    mask[BIT_JABBER]      = 1'b1;
    return mask;
  endfunction

  // one bit set at every diagnostic field position
  function automatic logic [15:0] diagPositions();
    logic [15:0] mask;
    mask                  = '0;
    mask[DIAG_RX_LOCK]    = 1'b1;
    mask[DIAG_RX_SIGNAL]  = 1'b1;
    mask[DIAG_RATE_100]   = 1'b1;
    mask[DIAG_FULL_RESOLVED_FULL_DUPLEX]  = 1'b1;
    mask[DIAG_NEG_FAILED] = 1'b1;
    return mask;
  endfunction

  // read word of the event register: enables above, flags below
  function automatic logic [15:0] eventWord(
    input logic [NUM_EVENTS-1:0] enables,
    input logic [NUM_EVENTS-1:0] pending
  );
    logic [15:0] word;
    word                           = EVT_RESET;
    word[ENABLE_LSB +: NUM_EVENTS] = enables;
    word[NUM_EVENTS-1:0]           = pending;
    return word;
  endfunction

  // diagnostic word: sticky failure and live negotiation outcome; the
  // upper three and lower eight bits stay at their reset value of zero
  function automatic logic [15:0] diagnosticWord(
    input logic failed,
    input logic fullDuplex,
    input logic rate100,
    input logic signalSeen,
    input logic pllLocked
  );
    logic [15:0] word;
    word                  = DIAG_RESET;
    word[DIAG_NEG_FAILED] = failed;
    word[DIAG_FULL_RESOLVED_FULL_DUPLEX]  = fullDuplex;
    word[DIAG_RATE_100]   = rate100;
    word[DIAG_RX_SIGNAL]  = signalSeen;
    word[DIAG_RX_LOCK]    = pllLocked;
    return word;
  endfunction

  // ==========================================================
  // elaboration checks
  // the ports and the read word are fixed at sixteen bits with one byte
  // of flags; refuse constants that no longer fit that shape
  if (NUM_EVENTS != 8) begin : gEventCount
    $error("event count must match the eight event ports");
  end
  if (ENABLE_LSB + NUM_EVENTS > $bits(regRdata)) begin : gEnableFit
    $error("enable field does not fit the register word");
  end
  if (ENABLE_LSB < NUM_EVENTS) begin : gEnableOverlap
    $error("enable field overlaps the flag byte");
  end
  if (flagPositions() != 16'h00ff) begin : gFlagField
    $error("event flags must fill the low byte once each");
  end
  if ((diagPositions() & 16'h00ff) != 16'h0000) begin : gDiagLow
    $error("diagnostic fields must stay out of the low byte");
  end
  if ($countones(diagPositions()) != 5) begin : gDiagField
    $error("diagnostic fields must not share a bit");
  end
  if (EVT_REG_ADDR == DIAG_REG_ADDR) begin : gAddrClash
    $error("event and diagnostic registers share an address");
  end
  if (EVT_RESET[NUM_EVENTS-1:0] != '0) begin : gFlagReset
    $error("event flags always reset to zero");
  end
  if ((DIAG_RESET & ~diagPositions()) != 16'h0000) begin : gDiagReset
    $error("unused diagnostic bits must reset to zero");
  end

  // ==========================================================
  // decode
  logic evtRead;
  logic evtWrite;
  logic diagRead;

  always_comb begin
    evtRead  = regHit(regRead, regAddr, EVT_REG_ADDR);
    // a read and a write together count as a read only
    evtWrite = regHit(regWrite & ~regRead, regAddr, EVT_REG_ADDR);
    diagRead = regHit(regRead, regAddr, DIAG_REG_ADDR);
  end

  // ==========================================================
  // event flags
  logic       linkFail;
  logic [7:0] events;
  logic [7:0] flags;

  pead_link_edge u_link_edge (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .linkOk   (linkOk),
    .linkFail (linkFail)
  );

  always_comb begin
    events                  = '0;
    events[BIT_JABBER]      = jabberEvent;
    events[BIT_RX_ERROR]    = rxErrorEvent;
    events[BIT_PAGE_RCVD]   = pageRcvdEvent;
    events[BIT_PDF]         = parDetectFaultEvent;
    events[BIT_PARTNER_ACK] = partnerAckEvent;
    events[BIT_LINK_CHANGE] = linkFail;
    events[BIT_RFAULT]      = remoteFaultEvent;
    events[BIT_NEG_DONE]    = negotiationDoneEvent;
  end

  pead_event_latch #(
    .WIDTH (NUM_EVENTS)
  ) u_event_latch (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .eventIn  (events),
    .clearReq (evtRead),
    .flags    (flags)
  );

  // ==========================================================
  // interrupt enables
  // written as the high byte of the event register
  logic [NUM_EVENTS-1:0] enable_reg;
  logic [NUM_EVENTS-1:0] enable_next;

  always_comb begin
    enable_next = enable_reg;
    if (evtWrite) begin
      // the flag byte of a write is dropped: flags only clear by reading
      enable_next = regWdata[ENABLE_LSB +: NUM_EVENTS];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_reg <= EVT_RESET[ENABLE_LSB +: NUM_EVENTS];
    end else begin
      enable_reg <= enable_next;
    end
  end

  // ==========================================================
  // negotiation failure, sticky until the diagnostic read
  logic negFail_reg;
  logic negFail_next;

  always_comb begin
    // a failure in the cycle of the clearing read stays latched
    negFail_next = (diagRead ? 1'b0 : negFail_reg)
                   | negotiationFailEvent;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      negFail_reg <= DIAG_RESET[DIAG_NEG_FAILED];
    end else begin
      negFail_reg <= negFail_next;
    end
  end

  // ==========================================================
  // read data, held until the next read
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (evtRead) begin
      rdata_next = eventWord(enable_reg, flags);
    end else if (diagRead) begin
      rdata_next = diagnosticWord(negFail_reg, resolvedFullDuplex,
                                  resolved100, rxSignalDetected,
                                  rxPllLocked);
    end else if (regRead) begin
      // unmapped addresses read as zero
      rdata_next = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_reg <= DIAG_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // interrupt toward the mac, one cycle behind the flags
  // a flag cleared by a read drops the interrupt one cycle later
  logic irq_reg;
  logic irq_next;

  always_comb begin
    irq_next = |(flags & enable_reg);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign regRdata = rdata_reg;
  assign phyIrq   = irq_reg;
endmodule // pead_event_diag

/* File: tb/pead_checker.sv */
/*
  port assertions for the event and diagnostic registers.
  assumes one core_clk domain; bound below.
*/
module pead_checker
  import pead_pkg::*;
(
  // watched ports
  input logic        core_clk,
  input logic        rst_n,
  input logic [4:0]  regAddr,
  input logic        regRead,
  input logic        regWrite,
  input logic [15:0] regWdata,
  input logic [15:0] regRdata,
  input logic        jabberEvent,
  input logic        linkOk,
  input logic        negotiationFailEvent,
  input logic        resolvedFullDuplex,
  input logic        phyIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic evtRd, diagRd;
  assign evtRd = regRead && regAddr == EVT_REG_ADDR;
  assign diagRd = regRead && regAddr == DIAG_REG_ADDR;
  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence clrTwice;
    (evtRd && !jabberEvent) ##1 (evtRd && !jabberEvent);
  endsequence
  sequence jabArmed;
    (regWrite && !regRead && regAddr == EVT_REG_ADDR && regWdata[15])
      ##1 (jabberEvent && !regWrite);
  endsequence
  rd_hold_a: assert property (!regRead |=> $stable(regRdata))
    else $error("read data moved");
  diag_zero_a: assert property (diagRd |=> regRdata[15:13] == 3'h0
    && regRdata[7:0] == 8'h00) else $error("diag unused bits");
  resolved_full_duplex_live_a: assert property (diagRd |=>
    regRdata[11] == $past(resolvedFullDuplex)) else $error("duplex bit");
  jab_flag_a: assert property (jabberEvent ##1 evtRd |=> regRdata[7])
    else $error("jabber flag");
  rd_clear_a: assert property (clrTwice |=> !regRdata[7])
    else $error("flag not cleared");
  link_flag_a: assert property ($fell(linkOk) && !evtRd ##1 evtRd
    |=> regRdata[2]) else $error("link flag");
  neg_fail_a: assert property (negotiationFailEvent ##1 diagRd
    |=> regRdata[12]) else $error("failure bit");
  irq_arm_a: assert property (jabArmed |-> ##2 phyIrq)
    else $error("irq missing");
endmodule // pead_checker

bind pead_event_diag pead_checker i_pead_checker (.*);

/* File: tb/pead_mgmt_ctrl.sv */
/*
  management controller model: one-cycle register requests.
  assumes issue is called just after a falling clock edge.
*/
module pead_mgmt_ctrl (
  // register requests
  output logic [4:0]  regAddr,
  output logic        regRead,
  output logic        regWrite,
  output logic [15:0] regWdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // kind 0/1 poll, 2 enable write, 3 unmapped, 4 read-only write
  task automatic issue(input logic [2:0] kind, input logic [15:0] d);
    regRead = kind inside {3'h0, 3'h1, 3'h3};
    regWrite = kind inside {3'h2, 3'h4};
    regAddr = kind == 3'h3 ? 5'h13 : (kind inside {3'h1, 3'h4}) ? 5'h12
      : 5'h11;
    regWdata = d;
  endtask
endmodule // pead_mgmt_ctrl

/* File: tb/testbench.sv */
/*
  random events and register traffic compared with a bench model.
  assumes the design, its bound checker and the controller model.
*/
module testbench import pead_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst_n = 1'b0, linkOk = 1'b0;
  logic [7:0]  evs = 8'h00;
  logic [3:0]  lvl = 4'h0;
  logic        negFail = 1'b0, regRead, regWrite, phyIrq;
  logic [4:0]  regAddr;
  logic [15:0] regWdata, regRdata;
  logic [31:0] rnd = 32'h1d790db8;
  int en, fl, nf, prevLink, expRd, expIrq, bad_count, tests_run, cyc;
  pead_mgmt_ctrl i_pead_mgmt_ctrl (.regAddr(regAddr), .regRead(regRead),
    .regWrite(regWrite), .regWdata(regWdata));
  pead_event_diag i_pead_event_diag (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .jabberEvent(evs[7]),
    .rxErrorEvent(evs[6]), .pageRcvdEvent(evs[5]),
    .parDetectFaultEvent(evs[4]), .partnerAckEvent(evs[3]),
    .linkOk(linkOk), .remoteFaultEvent(evs[1]),
    .negotiationDoneEvent(evs[0]), .negotiationFailEvent(negFail),
    .resolvedFullDuplex(lvl[3]), .resolved100(lvl[2]),
    .rxSignalDetected(lvl[1]), .rxPllLocked(lvl[0]), .phyIrq(phyIrq));
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      give_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // model steps on the inputs taken at the last rising edge
  initial begin
    i_pead_mgmt_ctrl.issue(3'h7, 16'h0000);
    for (int i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      expIrq = (fl & en) != 0;
      if (!rst_n) begin
        {en, fl, nf, expRd, expIrq} = '0;
      end else begin
        if (regRead && regAddr == EVT_REG_ADDR) begin
          expRd = en << 8 | fl;
          fl = 0;
        end else if (regRead && regAddr == DIAG_REG_ADDR) begin
          expRd = nf << 12 | lvl << 8;
          nf = 0;
        end else if (regRead) expRd = 0;
        else if (regWrite && regAddr == EVT_REG_ADDR) en = regWdata[15:8];
        fl |= evs & 8'hfb;
        if (prevLink == 1 && !linkOk) fl |= 4;
        nf |= negFail;
      end
      prevLink = linkOk;
      check("read data", regRdata, expRd[15:0]);
      check("interrupt", {15'h0, phyIrq}, expIrq[15:0]);
      rnd = lfsr(rnd);
      rst_n = !(i < 2 || (i > 1500 && i < 1504));
      for (int k = 0; k < 8; k++) evs[k] = rnd[4*k+:3] == 3'h0;
      rnd = lfsr(rnd);
      negFail = rnd[4:0] == 5'h00;
      lvl = rnd[8:5];
      linkOk = rst_n && (rnd[11:9] == 3'h0 ? !linkOk : linkOk);
      i_pead_mgmt_ctrl.issue(rnd[14:12], rnd[31:16]);
    end
    give_verdict();
  end
endmodule // testbench
